/* core/cap_pkg.sv */
// Shared constants for the current-channel converter post-processing block.
`default_nettype none
package cap_pkg;
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned ACCUM_W  = 32;
  localparam int unsigned DECIM_W  = 17;
  localparam int unsigned FILT_W   = 56;

  // Modulator sample rates in Hz, one per power mode.
  localparam int unsigned MOD_RATE_NORMAL_HZ = 512000;
  localparam int unsigned MOD_RATE_LOWPWR_HZ = 128000;

  // Output rate limits in Hz.
  localparam int unsigned OUT_NORMAL_MIN_HZ = 4;
  localparam int unsigned OUT_NORMAL_MAX_HZ = 8000;
  localparam int unsigned OUT_LOWPWR_MIN_HZ = 1;
  localparam int unsigned OUT_LOWPWR_MAX_HZ = 2000;

  // Decimation ratio limits derived from the rates above.
  localparam logic [DECIM_W-1:0] DECIM_NORMAL_MIN =
    DECIM_W'(MOD_RATE_NORMAL_HZ / OUT_NORMAL_MAX_HZ);
  localparam logic [DECIM_W-1:0] DECIM_NORMAL_MAX =
    DECIM_W'(MOD_RATE_NORMAL_HZ / OUT_NORMAL_MIN_HZ);
  localparam logic [DECIM_W-1:0] DECIM_LOWPWR_MIN =
    DECIM_W'(MOD_RATE_LOWPWR_HZ / OUT_LOWPWR_MAX_HZ);
  localparam logic [DECIM_W-1:0] DECIM_LOWPWR_MAX =
    DECIM_W'(MOD_RATE_LOWPWR_HZ / OUT_LOWPWR_MIN_HZ);

  // Reset value of the conversion count limit.
  localparam logic [RESULT_W-1:0] COUNT_LIMIT_RST = 16'h0001;

  // Conversion cycles until the first settled result, per chop setting.
  localparam logic [1:0] SETTLE_CHOP_OFF = 2'h3;
  localparam logic [1:0] SETTLE_CHOP_ON  = 2'h2;
endpackage
`default_nettype wire

/* core/cap_filt_if.sv */
// Link between the control logic and the decimating filter.
`timescale 1ns/1ps
`default_nettype none
interface cap_filt_if;
  logic                         restart;
  logic [cap_pkg::DECIM_W-1:0]  decim;
  logic [cap_pkg::RESULT_W-1:0] result;
  logic                         result_valid;

  modport filt (input restart, input decim, output result,
                output result_valid);
  modport ctrl (output restart, output decim, input result,
                input result_valid);
endinterface
`default_nettype wire

/* core/cap_decim_filter.sv */
// Third-order decimating low-pass filter for the modulator bit stream.
`timescale 1ns/1ps
`default_nettype none
module cap_decim_filter (
  input  wire logic   i_clk,
  input  wire logic   i_reset,
  input  wire logic   i_ce,
  input  wire logic   i_mod_bit,
  input  wire logic   i_mod_valid,
  cap_filt_if.filt    bus
);
  localparam int unsigned FW = cap_pkg::FILT_W;
  localparam int unsigned DW = cap_pkg::DECIM_W;

  typedef struct packed {
    logic [2:0][FW-1:0]             integ;
    logic [2:0][FW-1:0]             dly;
    logic [DW-1:0]                  phase;
    logic [cap_pkg::RESULT_W-1:0]   result;
    logic                           result_valid;
  } cap_filt_state_type;

  cap_filt_state_type s_q;
  cap_filt_state_type s_d;

  function automatic logic [7:0] ceil_log2(input logic [DW-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < DW; i++) begin
      if ((DW'(1) << i) < v) begin
        n = 8'(i + 1);
      end
    end
    return n;
  endfunction

  logic signed [FW-1:0] comb_val;
  logic signed [FW-1:0] scaled;
  logic [7:0]           shift;
  logic signed [FW-1:0] in_val;

  always_comb begin
    s_d = s_q;
    s_d.result_valid = 1'b0;
    comb_val = '0;
    scaled = '0;
    // The gain of a third-order stage is the ratio cubed; shifting by the
    // rounded-up power of two keeps the result in range without a divider.
    shift = 8'(3 * ceil_log2(bus.decim) - 15);
    in_val = i_mod_bit ? FW'(1) : -FW'(1);
    if (bus.restart) begin
      s_d.integ = '0;
      s_d.dly = '0;
      s_d.phase = '0;
    end else if (i_mod_valid) begin
      s_d.integ[0] = s_q.integ[0] + in_val;
      for (int k = 1; k < 3; k++) begin
        s_d.integ[k] = s_q.integ[k] + s_q.integ[k-1];
      end
      if (s_q.phase >= bus.decim - DW'(1)) begin
        s_d.phase = '0;
        comb_val = s_q.integ[2];
        for (int k = 0; k < 3; k++) begin
          s_d.dly[k] = comb_val;
          comb_val = comb_val - $signed(s_q.dly[k]);
        end
        scaled = comb_val >>> shift;
        if (scaled > FW'(32767)) begin
          s_d.result = 16'h7fff;
        end else if (scaled < -FW'(32768)) begin
          s_d.result = 16'h8000;
        end else begin
          s_d.result = scaled[cap_pkg::RESULT_W-1:0];
        end
        s_d.result_valid = 1'b1;
      end else begin
        s_d.phase = s_q.phase + DW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign bus.result       = s_q.result;
  assign bus.result_valid = s_q.result_valid & i_ce;
endmodule
`default_nettype wire

/* core/cap_post_proc.sv */
// Current-channel post-processing: rate control, settling, count,
// threshold and accumulation.
`timescale 1ns/1ps
`default_nettype none
module cap_post_proc #(
  parameter int unsigned DECIM_W = cap_pkg::DECIM_W
) (
  input  wire logic                          I_CLK,
  input  wire logic                          I_RESET,
  input  wire logic                          I_CE,
  input  wire logic                          I_MOD_BIT,
  input  wire logic                          I_MOD_VALID,
  input  wire logic                          I_ENABLE,
  input  wire logic                          I_LOW_POWER,
  input  wire logic                          I_CHOP,
  input  wire logic [DECIM_W-1:0]            I_DECIM,
  input  wire logic                          I_LIMIT_WR,
  input  wire logic [cap_pkg::RESULT_W-1:0]  I_LIMIT_DATA,
  input  wire logic [cap_pkg::RESULT_W-1:0]  I_THRESHOLD,
  input  wire logic                          I_ACC_EN,
  input  wire logic                          I_ACC_CLR,
  input  wire logic                          I_COUNT_ACK,
  input  wire logic                          I_THRESH_ACK,
  output logic [cap_pkg::RESULT_W-1:0]       O_RESULT,
  output logic                               O_RESULT_VALID,
  output logic                               O_SETTLED,
  output logic [cap_pkg::RESULT_W-1:0]       O_COUNT_LIMIT,
  output logic [cap_pkg::RESULT_W-1:0]       O_COUNT_VALUE,
  output logic [cap_pkg::ACCUM_W-1:0]        O_ACCUM,
  output logic                               O_COUNT_IRQ,
  output logic                               O_THRESH_IRQ
);
  localparam int unsigned RW = cap_pkg::RESULT_W;
  localparam int unsigned AW = cap_pkg::ACCUM_W;

  if (DECIM_W != cap_pkg::DECIM_W) begin : g_bad_width
    $error("DECIM_W must match the filter ratio width");
  end

  // The filter scales by a shift of three times the rounded-up log2 of
  // the ratio, less fifteen; ratios of 32 and up keep it from going
  // negative.
  if (cap_pkg::DECIM_NORMAL_MIN < 17'h00020 ||
      cap_pkg::DECIM_LOWPWR_MIN < 17'h00020) begin : g_bad_ratio
    $error("Minimum ratio too small for the filter scaling");
  end

  // Everything the control logic remembers lives in this one record, so the
  // clock-enable freeze and the reset cover all of it at once.
  typedef struct packed {
    logic                 enabled;
    logic                 low_power;
    logic                 chop;
    logic [DECIM_W-1:0]   decim;
    logic                 restart;
    logic [1:0]           settle_cnt;
    logic [RW-1:0]        result;
    logic                 result_valid;
    logic                 settled;
    logic [RW-1:0]        count_limit;
    logic [RW-1:0]        count_value;
    logic [AW-1:0]        accum;
    logic                 count_irq;
    logic                 thresh_irq;
  } cap_ctrl_state_type;

  cap_ctrl_state_type s_q;
  cap_ctrl_state_type s_d;

  cap_filt_if filt_bus ();

  // Samples are gated with the registered enable, so a disabled channel
  // leaves the filter history alone until the restart clears it.
  cap_decim_filter u_filter (
    .i_clk       (I_CLK),
    .i_reset     (I_RESET),
    .i_ce        (I_CE),
    .i_mod_bit   (I_MOD_BIT),
    .i_mod_valid (I_MOD_VALID & s_q.enabled),
    .bus         (filt_bus.filt)
  );

  // Pulls a requested ratio into the range that the power mode allows.
  // A request outside the range is clamped without any flag, so software
  // cannot tell from the ports that its request was changed.
  function automatic logic [DECIM_W-1:0] clamp_decim(
    input logic [DECIM_W-1:0] req,
    input logic               low_pwr
  );
    logic [DECIM_W-1:0] lo;
    logic [DECIM_W-1:0] hi;
    lo = low_pwr ? cap_pkg::DECIM_LOWPWR_MIN : cap_pkg::DECIM_NORMAL_MIN;
    hi = low_pwr ? cap_pkg::DECIM_LOWPWR_MAX : cap_pkg::DECIM_NORMAL_MAX;
    if (req < lo) begin
      return lo;
    end else if (req > hi) begin
      return hi;
    end
    return req;
  endfunction

  logic [DECIM_W-1:0] decim_req;
  logic [1:0]         settle_need;
  logic               good;
  logic [RW:0]        magnitude;
  logic               count_hit;
  logic               thresh_hit;

  always_comb begin
    s_d = s_q;
    s_d.result_valid = 1'b0;
    s_d.restart = 1'b0;
    decim_req = clamp_decim(I_DECIM, I_LOW_POWER);
    settle_need = s_q.chop ? cap_pkg::SETTLE_CHOP_ON
                           : cap_pkg::SETTLE_CHOP_OFF;
    good = 1'b0;
    magnitude = '0;
    count_hit = 1'b0;
    thresh_hit = 1'b0;

    s_d.enabled = I_ENABLE;
    s_d.low_power = I_LOW_POWER;
    s_d.chop = I_CHOP;
    s_d.decim = decim_req;
    // Any change of setup throws away the filter history, since results
    // mixing two ratios or modes would be meaningless.
    if ((I_ENABLE && !s_q.enabled) || I_LOW_POWER != s_q.low_power ||
        I_CHOP != s_q.chop || decim_req != s_q.decim) begin
      s_d.restart = 1'b1;
      s_d.settle_cnt = '0;
      s_d.settled = 1'b0;
    end else if (!s_q.restart && filt_bus.result_valid) begin
      // The count stops at the target, and two bits would wrap if it were
      // incremented past it, so the test is against one less.
      if (s_q.settle_cnt >= settle_need - 2'h1) begin
        good = 1'b1;
        s_d.settle_cnt = settle_need;
      end else begin
        s_d.settle_cnt = s_q.settle_cnt + 2'h1;
      end
    end
    if (!I_ENABLE) begin
      s_d.settled = 1'b0;
      s_d.settle_cnt = '0;
    end

    if (good) begin
      s_d.settled = 1'b1;
      s_d.result = filt_bus.result;
      s_d.result_valid = 1'b1;
      // A limit of zero keeps the count interrupt quiet instead of firing
      // once in 65536 results when the value wraps.
      if (s_q.count_limit != '0 &&
          s_q.count_value + RW'(1) == s_q.count_limit) begin
        count_hit = 1'b1;
        s_d.count_value = '0;
      end else begin
        s_d.count_value = s_q.count_value + RW'(1);
      end
      // The magnitude lets one unsigned threshold catch current in both
      // directions; full-scale negative counts as 32768.
      magnitude = filt_bus.result[RW-1]
                ? (RW+1)'(-$signed({1'b1, filt_bus.result}))
                : {1'b0, filt_bus.result};
      thresh_hit = magnitude > {1'b0, I_THRESHOLD};
    end

    if (I_LIMIT_WR) begin
      s_d.count_limit = I_LIMIT_DATA;
      s_d.count_value = '0;
    end

    // The sum wraps without warning; at full scale it lasts 65536 results,
    // so software must read and clear it well before then.
    if (I_ACC_CLR) begin
      s_d.accum = '0;
    end else if (good && I_ACC_EN) begin
      s_d.accum = s_q.accum + AW'($signed(filt_bus.result));
    end

    // A new event wins over an acknowledge in the same cycle.
    if (count_hit) begin
      s_d.count_irq = 1'b1;
    end else if (I_COUNT_ACK) begin
      s_d.count_irq = 1'b0;
    end
    if (thresh_hit) begin
      s_d.thresh_irq = 1'b1;
    end else if (I_THRESH_ACK) begin
      s_d.thresh_irq = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      s_q <= '0;
      // A zero ratio would give the filter a negative scaling shift, so
      // the ratio starts at the smallest legal value instead.
      s_q.decim <= cap_pkg::DECIM_NORMAL_MIN;
      s_q.count_limit <= cap_pkg::COUNT_LIMIT_RST;
    end else if (I_CE) begin
      s_q <= s_d;
    end
  end

  assign filt_bus.restart = s_q.restart;
  assign filt_bus.decim   = s_q.decim;

  // Every output is a field of the state record, so each one comes
  // straight from a flip-flop.
  assign O_RESULT       = s_q.result;
  assign O_RESULT_VALID = s_q.result_valid;
  assign O_SETTLED      = s_q.settled;
  assign O_COUNT_LIMIT  = s_q.count_limit;
  assign O_COUNT_VALUE  = s_q.count_value;
  assign O_ACCUM        = s_q.accum;
  assign O_COUNT_IRQ    = s_q.count_irq;
  assign O_THRESH_IRQ   = s_q.thresh_irq;
endmodule
`default_nettype wire

/* test/cap_mod_model.sv */
// Behavioural modulator: one sample per cycle at a fixed density.
`timescale 1ns/1ps
`default_nettype none
module cap_mod_model (
  input  wire logic i_clk,
  input  wire logic i_run,
  input  wire logic i_level,
  output var  logic o_bit,
  output var  logic o_valid
);
  initial {o_bit, o_valid} = 2'h0;
  // While stopped the bit toggles so that no stale level looks valid.
  always @(negedge i_clk) begin
    o_valid <= i_run;
    o_bit   <= i_run ? i_level : ~o_bit;
  end
endmodule
`default_nettype wire

/* test/cap_post_proc_sva.sv */
// Concurrent checks on the ports of the post-processing block.
`timescale 1ns/1ps
`default_nettype none
module cap_post_proc_chk (
  input wire logic        I_CLK,
  input wire logic        I_RESET,
  input wire logic        I_LIMIT_WR,
  input wire logic [15:0] I_LIMIT_DATA,
  input wire logic [15:0] I_THRESHOLD,
  input wire logic        I_ACC_EN,
  input wire logic        I_ACC_CLR,
  input wire logic        I_COUNT_ACK,
  input wire logic        I_THRESH_ACK,
  input wire logic [15:0] O_RESULT,
  input wire logic        O_RESULT_VALID,
  input wire logic        O_SETTLED,
  input wire logic [15:0] O_COUNT_LIMIT,
  input wire logic [15:0] O_COUNT_VALUE,
  input wire logic [31:0] O_ACCUM,
  input wire logic        O_COUNT_IRQ,
  input wire logic        O_THRESH_IRQ
);
  logic [16:0] mag;
  assign mag = O_RESULT[15] ? 17'h10000 - {1'h0, O_RESULT} : {1'h0, O_RESULT};
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  chk_limit_reset: assert property ($fell(I_RESET) |->
    O_COUNT_LIMIT == 16'h0001 && O_COUNT_VALUE == 16'h0000)
    else $error("count limit wrong after reset");
  chk_limit_load: assert property (I_LIMIT_WR |=>
    O_COUNT_LIMIT == $past(I_LIMIT_DATA) && O_COUNT_VALUE == 16'h0000)
    else $error("limit write not taken");
  chk_valid_single: assert property (O_RESULT_VALID |=>
    (!O_RESULT_VALID)[*8]) else $error("results too close");
  chk_count_fire: assert property ($rose(O_COUNT_IRQ) |->
    O_RESULT_VALID && O_COUNT_VALUE == 16'h0000)
    else $error("count flag without wrap");
  chk_count_hold: assert property (!O_RESULT_VALID &&
    !$past(I_LIMIT_WR) |-> $stable(O_COUNT_VALUE))
    else $error("count moved without result");
  chk_count_ack: assert property ($past(I_COUNT_ACK) &&
    !O_RESULT_VALID |-> !O_COUNT_IRQ) else $error("count flag not cleared");
  chk_thresh_set: assert property ($rose(O_THRESH_IRQ) |->
    O_RESULT_VALID && mag > {1'h0, $past(I_THRESHOLD)})
    else $error("threshold flag without cause");
  chk_thresh_fire: assert property (O_RESULT_VALID &&
    mag > {1'h0, $past(I_THRESHOLD)} |-> O_THRESH_IRQ)
    else $error("threshold flag missed");
  chk_thresh_ack: assert property ($past(I_THRESH_ACK) &&
    !O_RESULT_VALID |-> !O_THRESH_IRQ)
    else $error("threshold flag not cleared");
  chk_accum_add: assert property (O_RESULT_VALID && $past(I_ACC_EN) &&
    !$past(I_ACC_CLR) |-> O_ACCUM == $past(O_ACCUM) +
    {{16{O_RESULT[15]}}, O_RESULT}) else $error("accumulator sum wrong");
  chk_accum_hold: assert property (!O_RESULT_VALID &&
    !$past(I_ACC_CLR) |-> $stable(O_ACCUM)) else $error("accumulator moved");
  chk_settled_rise: assert property ($rose(O_SETTLED) |->
    O_RESULT_VALID) else $error("settled without result");
  cov_count: cover property (O_COUNT_IRQ && O_RESULT_VALID);
  cov_thresh: cover property ($rose(O_THRESH_IRQ));
  cov_accum: cover property (O_RESULT_VALID && $past(I_ACC_EN));
  cov_negative: cover property (O_RESULT_VALID && O_RESULT[15]);
endmodule
bind cap_post_proc cap_post_proc_chk u_chk (.I_CLK(I_CLK),
  .I_RESET(I_RESET), .I_LIMIT_WR(I_LIMIT_WR), .I_LIMIT_DATA(I_LIMIT_DATA),
  .I_THRESHOLD(I_THRESHOLD), .I_ACC_EN(I_ACC_EN), .I_ACC_CLR(I_ACC_CLR),
  .I_COUNT_ACK(I_COUNT_ACK), .I_THRESH_ACK(I_THRESH_ACK),
  .O_RESULT(O_RESULT),
  .O_RESULT_VALID(O_RESULT_VALID), .O_SETTLED(O_SETTLED),
  .O_COUNT_LIMIT(O_COUNT_LIMIT), .O_COUNT_VALUE(O_COUNT_VALUE),
  .O_ACCUM(O_ACCUM), .O_COUNT_IRQ(O_COUNT_IRQ), .O_THRESH_IRQ(O_THRESH_IRQ));
`default_nettype wire

/* test/tb_cap_post_proc.sv */
// Self-checking bench for the current-channel post-processing block.
`timescale 1ns/1ps
`default_nettype none
module tb_cap_post_proc;
  logic        I_CLK = 1'b0, I_RESET = 1'b1, I_ENABLE = 1'b0;
  logic        I_LOW_POWER = 1'b0, I_CHOP = 1'b0, I_LIMIT_WR = 1'b0;
  logic        I_ACC_EN = 1'b0, I_ACC_CLR = 1'b0, I_COUNT_ACK = 1'b0;
  logic        I_THRESH_ACK = 1'b0, run = 1'b0, I_MOD_BIT, I_MOD_VALID;
  logic        I_CE = 1'b1, level = 1'b1;
  logic        O_RESULT_VALID, O_SETTLED, O_COUNT_IRQ, O_THRESH_IRQ;
  logic [16:0] I_DECIM = 17'h00000;
  logic [15:0] I_LIMIT_DATA = 16'h0000, I_THRESHOLD = 16'hffff;
  logic [15:0] O_RESULT, O_COUNT_LIMIT, O_COUNT_VALUE;
  logic [31:0] O_ACCUM, a0;
  int          err_total = 0, cmp_count = 0, n;
  int          dec [4] = '{0, 10, 100, 200};
  int          rt  [4] = '{64, 64, 100, 200};

  cap_mod_model u_mod (.i_clk(I_CLK), .i_run(run), .i_level(level),
    .o_bit(I_MOD_BIT), .o_valid(I_MOD_VALID));
  cap_post_proc #(.DECIM_W(17)) dut (.I_CLK(I_CLK), .I_RESET(I_RESET),
    .I_CE(I_CE), .I_MOD_BIT(I_MOD_BIT), .I_MOD_VALID(I_MOD_VALID),
    .I_ENABLE(I_ENABLE), .I_LOW_POWER(I_LOW_POWER), .I_CHOP(I_CHOP),
    .I_DECIM(I_DECIM), .I_LIMIT_WR(I_LIMIT_WR), .I_LIMIT_DATA(I_LIMIT_DATA),
    .I_THRESHOLD(I_THRESHOLD), .I_ACC_EN(I_ACC_EN), .I_ACC_CLR(I_ACC_CLR),
    .I_COUNT_ACK(I_COUNT_ACK), .I_THRESH_ACK(I_THRESH_ACK),
    .O_RESULT(O_RESULT), .O_RESULT_VALID(O_RESULT_VALID),
    .O_SETTLED(O_SETTLED), .O_COUNT_LIMIT(O_COUNT_LIMIT),
    .O_COUNT_VALUE(O_COUNT_VALUE), .O_ACCUM(O_ACCUM),
    .O_COUNT_IRQ(O_COUNT_IRQ), .O_THRESH_IRQ(O_THRESH_IRQ));

  always #25 I_CLK = ~I_CLK;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Counts falling edges until the next result pulse, then steps past it.
  task automatic wait_res();
    n = 0;
    while (O_RESULT_VALID !== 1'b1) begin
      @(negedge I_CLK);
      n++;
      if (n > 3000) begin
        err_total++;
        $display("BAD result_pulse expected 1 seen 0");
        summarize();
      end
    end
    @(negedge I_CLK);
  endtask

  // Drops the enable for a cycle so that the restart is always seen.
  task automatic start(input logic lp, ch, input logic [16:0] d);
    @(negedge I_CLK);
    I_ENABLE = 1'b0;
    @(negedge I_CLK);
    {I_LOW_POWER, I_CHOP, I_DECIM, I_ENABLE} = {lp, ch, d, 1'b1};
    wait_res();
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge I_CLK);
    s = 1'b0;
  endtask

  initial begin
    repeat (3) @(negedge I_CLK);
    I_RESET = 1'b0;
    run = 1'b1;
    chk("limit", O_COUNT_LIMIT, 32'h1);
    chk("accum", O_ACCUM, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      start(i[0], i[0] ^ i[1], 17'(dec[i]));
      a0 = 32'((i[0] ^ i[1]) ? 2 * rt[i] : 3 * rt[i]);
      chk("settle", 32'(n >= a0 && n <= a0 + 6), 32'h1);
      wait_res();
      chk("rate", 32'(n + 1), 32'(rt[i]));
    end
    $display("test rates done");
    start(1'b0, 1'b0, 17'h00000);
    chk("result", O_RESULT, 32'h7fff);
    chk("settled", O_SETTLED, 32'h1);
    chk("cnt_irq", O_COUNT_IRQ, 32'h1);
    I_LIMIT_DATA = 16'h0003;
    pulse(I_LIMIT_WR);
    pulse(I_COUNT_ACK);
    chk("limit", O_COUNT_LIMIT, 32'h3);
    wait_res();
    wait_res();
    chk("count", O_COUNT_VALUE, 32'h2);
    chk("cnt_irq", O_COUNT_IRQ, 32'h0);
    wait_res();
    chk("cnt_irq", O_COUNT_IRQ, 32'h1);
    $display("test count done");
    I_THRESHOLD = 16'h7fff;
    wait_res();
    chk("thr_irq", O_THRESH_IRQ, 32'h0);
    I_THRESHOLD = 16'h7ffe;
    wait_res();
    chk("thr_irq", O_THRESH_IRQ, 32'h1);
    $display("test threshold done");
    I_ACC_EN = 1'b1;
    pulse(I_ACC_CLR);
    wait_res();
    wait_res();
    chk("accum", O_ACCUM, 32'hfffe);
    a0 = O_ACCUM;
    start(1'b0, 1'b0, 17'h00000);
    chk("accum", O_ACCUM, a0 + 32'h7fff);
    chk("count", O_COUNT_VALUE, 32'h2);
    pulse(I_ACC_CLR);
    chk("accum", O_ACCUM, 32'h0);
    $display("test accumulate done");
    pulse(I_THRESH_ACK);
    chk("thr_irq", O_THRESH_IRQ, 32'h0);
    level = 1'b0;
    start(1'b0, 1'b0, 17'h00000);
    chk("result", O_RESULT, 32'h8000);
    chk("thr_irq", O_THRESH_IRQ, 32'h1);
    chk("accum", O_ACCUM, 32'hffff8000);
    $display("test negative done");
    a0 = O_ACCUM;
    I_CE = 1'b0;
    n = 0;
    repeat (200) begin
      @(negedge I_CLK);
      if (O_RESULT_VALID !== 1'b0) begin
        n++;
      end
    end
    chk("ce_valid", 32'(n), 32'h0);
    chk("ce_accum", O_ACCUM, a0);
    I_CE = 1'b1;
    wait_res();
    chk("ce_accum", O_ACCUM, a0 + 32'hffff8000);
    $display("test freeze done");
    summarize();
  end
endmodule
`default_nettype wire
